// >>> pwm_fault_disable_enable.sv
/*
 * Fault protection and enable control of a six-output PWM generator:
 * fault filters, banks, write-once mapping, re-enable modes, event flags,
 * interrupt latches and module enable sequencing.
 * Assumes fault pins are asynchronous, generator pwm_raw_i and
 * cycle_start_i come from the same clock domain.
 */
`timescale 1ns/1ps

module pwm_fault_disable_enable (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  fault_pin_i,
   input  wire logic        soft_disable_bank_a_i,
   input  wire logic        soft_disable_bank_b_i,
   input  wire logic [7:0]  disable_map_wdata_i,
   input  wire logic        disable_map_we_i,
   input  wire logic [3:0]  fault_reenable_auto_i,
   input  wire logic [3:0]  fault_acknowledge_i,
   input  wire logic [3:0]  fault_irq_enable_i,
   input  wire logic        module_enable_i,
   input  wire logic        load_okay_i,
   input  wire logic        reload_irq_enable_i,
   input  wire logic        reload_flag_ack_i,
   input  wire logic        software_output_control_i,
   input  wire logic [5:0]  software_output_bit_i,
   input  wire logic [1:0]  prescaler_select_i,
   input  wire logic [11:0] modulus_buf_i,
   input  wire logic        cycle_start_i,
   input  wire logic [5:0]  pwm_raw_i,
   output logic      [3:0]  fault_pin_state_o,
   output logic      [3:0]  fault_event_flag_o,
   output logic      [3:0]  fault_irq_o,
   output logic             reload_flag_o,
   output logic             reload_irq_o,
   output logic      [7:0]  disable_map_o,
   output logic      [5:0]  pwm_o,
   output logic      [5:0]  pwm_oe_o,
   output logic      [11:0] modulus_used_o,
   output logic             load_values_o,
   output logic             generator_run_o
);
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic [3:0]  pin_r;
   logic [3:0]  pin_nxt;
   logic [3:0]  flag_r;
   logic [3:0]  irq_r;
   logic [3:0]  dis_r;
   logic [1:0]  soft_dis_r;
   logic [7:0]  map_r;
   logic        map_locked_r;
   logic        en_prev_r;
   logic        reload_flag_r;
   logic        reload_irq_r;
   logic [11:0] mod_r;
   logic        load_r;
   fault_ctl_pkg::en_state_e en_st_r;
   fault_ctl_pkg::en_state_e en_nxt;

   // filter: arm after one low sample, then count high samples
   wire [3:0] filt_rise;
   wire [3:0] filt_fall;
   genvar g;
   generate
      for (g = 0; g < fault_ctl_pkg::N_FAULT; g++) begin : g_filt
         fault_input_filter #(
            .CNT_MAX (fault_ctl_pkg::FILT_CNT_MAX)
         ) i_filt (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .level_i (sync2_r[g]),
            .state_i (pin_r[g]),
            .rise_o  (filt_rise[g]),
            .fall_o  (filt_fall[g])
         );
      end
   endgenerate

   // pin state only from the filter, no write path
   assign pin_nxt = (pin_r | filt_rise) & ~filt_fall;

   // re-enable evaluation point: cycle start, or every clock under software output control
   wire eval_pt = software_output_control_i || cycle_start_i;

   // clear conditions per input
   wire [3:0] ack_now   = fault_acknowledge_i & flag_r;
   wire [3:0] man_clear = ~flag_r & (fault_ctl_pkg::MANUAL_LEVEL_FREE | ~pin_r);
   wire [3:0] auto_clear = ~pin_r;
   wire [3:0] can_clear = (fault_reenable_auto_i & auto_clear) | (~fault_reenable_auto_i & man_clear);
   wire [3:0] dis_nxt   = (dis_r & ~(can_clear & {4{eval_pt}})) | pin_nxt & filt_rise | pin_r & ~can_clear;

   // banks: faults 1,2 + soft a, faults 3,4 + soft b
   wire bank_a = dis_r[0] | dis_r[1] | soft_dis_r[0];
   wire bank_b = dis_r[2] | dis_r[3] | soft_dis_r[1];
   wire bank_a_now = bank_a | filt_rise[0] | filt_rise[1] | soft_disable_bank_a_i;
   wire bank_b_now = bank_b | filt_rise[2] | filt_rise[3] | soft_disable_bank_b_i;

   // route banks to pairs through the map
   wire [3:0] map_a = map_r[fault_ctl_pkg::MAP_A_LO +: 4];
   wire [3:0] map_b = map_r[fault_ctl_pkg::MAP_B_LO +: 4];
   wire [3:0] hit   = (map_a & {4{bank_a_now}}) | (map_b & {4{bank_b_now}});
   wire [2:0] pair_dis = hit[2:0] | {3{hit[fault_ctl_pkg::MAP_ALL_BIT]}};
   wire [5:0] out_dis = {{2{pair_dis[2]}}, {2{pair_dis[1]}}, {2{pair_dis[0]}}};

   // source select: software bits or generator; disabled forced inactive
   // next state is used so that pins drive on the clock after enable with PRSC_DIV1
   wire [5:0] src     = software_output_control_i ? software_output_bit_i
                        : (en_nxt == fault_ctl_pkg::EN_DRIVE ? pwm_raw_i : 6'h00);
   wire       drive   = software_output_control_i || en_nxt == fault_ctl_pkg::EN_DRIVE;
   wire       en_rise = module_enable_i && !en_prev_r;

   // enable sequencing
   always_comb begin
      en_nxt = en_st_r;
      case (en_st_r)
         fault_ctl_pkg::EN_OFF: begin
            if (module_enable_i)
               en_nxt = (prescaler_select_i == fault_ctl_pkg::PRSC_DIV1) ? fault_ctl_pkg::EN_DRIVE : fault_ctl_pkg::EN_HOLDZ;
         end
         fault_ctl_pkg::EN_HOLDZ: begin
            if (!module_enable_i)
               en_nxt = fault_ctl_pkg::EN_OFF;
            else if (cycle_start_i)
               en_nxt = fault_ctl_pkg::EN_DRIVE;
         end
         fault_ctl_pkg::EN_DRIVE: begin
            if (!module_enable_i)
               en_nxt = fault_ctl_pkg::EN_OFF;
         end
         default: begin
            en_nxt = fault_ctl_pkg::EN_OFF;
         end
      endcase
   end

   // two-flop synchroniser for the asynchronous fault pins
   always_ff @(posedge clk_i) begin
      sync1_r <= fault_pin_i;
      sync2_r <= sync1_r;
   end

   // pin state and per-input disable
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_r <= 4'h0;
         dis_r <= 4'h0;
      end else begin
         pin_r <= pin_nxt;
         dis_r <= dis_nxt;
      end
   end

   // a new filtered edge wins over an acknowledge in the same cycle for the flag, and for the interrupt only while the flag is clear
   wire [3:0] flag_nxt = (flag_r & ~fault_acknowledge_i) | filt_rise;
   wire [3:0] irq_nxt  = ((irq_r & ~ack_now) | (filt_rise & ~flag_r)) & fault_irq_enable_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flag_r <= 4'h0;
         irq_r  <= 4'h0;
      end else begin
         flag_r <= flag_nxt;
         irq_r  <= irq_nxt;
      end
   end

   // soft disable: set at once, drop at evaluation point
   always_ff @(posedge clk_i) begin
      if (reset_i)
         soft_dis_r <= 2'h0;
      else
         soft_dis_r <= {soft_disable_bank_b_i, soft_disable_bank_a_i}
                       | (soft_dis_r & {2{!eval_pt}});
   end

   // write-once mapping
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         map_r        <= fault_ctl_pkg::MAP_RESET;
         map_locked_r <= 1'b0;
      end else if (disable_map_we_i && !map_locked_r) begin
         map_r        <= disable_map_wdata_i;
         map_locked_r <= 1'b1;
      end
   end

   // reload on first enable and at each cycle start while enabled
   wire reload_evt = en_rise || (module_enable_i && cycle_start_i);
   wire mod_load   = load_okay_i && (en_rise || cycle_start_i);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         en_prev_r <= 1'b0;
         en_st_r   <= fault_ctl_pkg::EN_OFF;
         load_r    <= 1'b0;
      end else begin
         en_prev_r <= module_enable_i;
         en_st_r   <= en_nxt;
         load_r    <= en_rise || (module_enable_i && cycle_start_i && load_okay_i);
      end
   end

   // modulus is not cleared by a disable; a cycle start with load_okay_i loads it even while disabled
   always_ff @(posedge clk_i) begin
      if (reset_i)
         mod_r <= fault_ctl_pkg::MOD_RESET;
      else if (mod_load)
         mod_r <= modulus_buf_i;
   end

   // reload flag and request survive a disable
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reload_flag_r <= 1'b0;
         reload_irq_r  <= 1'b0;
      end else begin
         if (reload_evt)
            reload_flag_r <= 1'b1;
         else if (reload_flag_ack_i)
            reload_flag_r <= 1'b0;
         if (reload_evt && reload_irq_enable_i)
            reload_irq_r <= 1'b1;
         else if (reload_flag_ack_i || !reload_irq_enable_i)
            reload_irq_r <= 1'b0;
      end
   end

   // output pins: registered level and drive enable per pin
   generate
      for (g = 0; g < fault_ctl_pkg::N_PWM; g++) begin : g_pin
         pwm_pin_stage i_pin (
            .clk_i     (clk_i),
            .reset_i   (reset_i),
            .level_i   (src[g]),
            .disable_i (out_dis[g]),
            .drive_i   (drive),
            .pin_o     (pwm_o[g]),
            .oe_o      (pwm_oe_o[g])
         );
      end
   endgenerate

   assign fault_pin_state_o  = pin_r;
   assign fault_event_flag_o = flag_r;
   assign fault_irq_o        = irq_r;
   assign reload_flag_o      = reload_flag_r;
   assign reload_irq_o       = reload_irq_r;
   assign disable_map_o      = map_r;
   assign modulus_used_o     = mod_r;
   assign load_values_o      = load_r;
   assign generator_run_o    = en_prev_r;
endmodule

// one fault input: arm on a low sample, then count high samples
module fault_input_filter #(
   parameter logic [1:0] CNT_MAX = fault_ctl_pkg::FILT_CNT_MAX
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic level_i,
   input  wire logic state_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic [1:0] hi_cnt_r;
   logic       armed_r;

   wire last_sample = (hi_cnt_r == CNT_MAX - 2'h1);
   wire counting    = armed_r && (hi_cnt_r != CNT_MAX);

   // second high sample of an armed edge is a genuine fault
   assign rise_o = armed_r && level_i && last_sample;
   // one low sample ends the pin state
   assign fall_o = state_i && !level_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hi_cnt_r <= 2'h0;
         armed_r  <= 1'b0;
      end else if (!level_i) begin
         // any low sample re-arms the edge detector
         hi_cnt_r <= 2'h0;
         armed_r  <= 1'b1;
      end else if (counting) begin
         hi_cnt_r <= hi_cnt_r + 2'h1;
         armed_r  <= !rise_o;
      end
   end
endmodule

// one output pin: registered level and drive enable
module pwm_pin_stage (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic level_i,
   input  wire logic disable_i,
   input  wire logic drive_i,
   output logic      pin_o,
   output logic      oe_o
);
   // a disabled pin is held at its inactive level
   wire level_nxt = level_i && !disable_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_o <= 1'b0;
         oe_o  <= 1'b0;
      end else begin
         pin_o <= level_nxt;
         oe_o  <= drive_i;
      end
   end
endmodule

// >>> fault_ctl_pkg.sv
/*
 * Package for the PWM fault disable and enable control block: widths,
 * bank layout, filter lengths and mapping constants.
 * Assumes a single 50 MHz clock and synchronous active-high reset.
 */
package fault_ctl_pkg;
   localparam int          N_FAULT     = 4;
   localparam int          N_PWM       = 6;
   localparam int          MAP_W       = 8;
   localparam int          CLK_MHZ     = 50;
   // filter: one low cycle of arming, two high samples
   localparam int          FILT_SAMPLES = 2;
   localparam logic [1:0]  FILT_CNT_MAX = 2'h2;
   localparam logic [1:0]  PRSC_DIV1    = 2'h0;
   // map bits: low nibble routes bank a, high nibble bank b
   localparam int          MAP_A_LO    = 0;
   localparam int          MAP_B_LO    = 4;
   localparam logic [7:0]  MAP_RESET   = 8'hFF;
   localparam logic [11:0] MOD_RESET   = 12'h000;
   // pairs 1/2, 3/4, 5/6 map to map bits 0,1,2; bit 3 covers all
   localparam int          MAP_ALL_BIT = 3;
   localparam logic [3:0]  MANUAL_LEVEL_FREE = 4'h5; // inputs 1 and 3

   typedef enum logic [1:0] {
      EN_OFF    = 2'b00,
      EN_HOLDZ  = 2'b01,
      EN_DRIVE  = 2'b10
   } en_state_e;
endpackage

// >>> pwm_fault_disable_enable_monitor.sv
/* Port checker for the PWM fault disable block.
   Assumes one clock and synchronous active-high reset. */
`timescale 1ns/1ps
module pwm_fault_monitor (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic [3:0] fault_acknowledge_i,
   input wire logic [3:0] fault_irq_enable_i,
   input wire logic       soft_disable_bank_a_i,
   input wire logic       module_enable_i,
   input wire logic [1:0] prescaler_select_i,
   input wire logic       software_output_control_i,
   input wire logic       reload_flag_ack_i,
   input wire logic       disable_map_we_i,
   input wire logic [3:0] fault_pin_state_o,
   input wire logic [3:0] fault_event_flag_o,
   input wire logic [3:0] fault_irq_o,
   input wire logic       reload_flag_o,
   input wire logic [7:0] disable_map_o,
   input wire logic [5:0] pwm_o,
   input wire logic [5:0] pwm_oe_o
);
   logic written_r;
   always_ff @(posedge clk_i) begin
      if (reset_i)
         written_r <= 1'b0;
      else if (disable_map_we_i)
         written_r <= 1'b1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   map_once_a: assert property (written_r && disable_map_we_i |=> $stable(disable_map_o))
      else $error("map changed twice");
   flag_edge_a: assert property ((fault_event_flag_o & ~$past(fault_event_flag_o) & ~fault_pin_state_o) == 4'h0)
      else $error("flag set without pin state");
   flag_hold_a: assert property (fault_event_flag_o[0] && !fault_acknowledge_i[0] |=> fault_event_flag_o[0])
      else $error("flag lost");
   ack_clr_a: assert property (fault_acknowledge_i[1] |=> !fault_event_flag_o[1] || $rose(fault_pin_state_o[1]))
      else $error("ack ignored");
   irq_en_a: assert property (!fault_irq_enable_i[2] |=> !fault_irq_o[2])
      else $error("irq without enable");
   irq_set_a: assert property ($rose(fault_event_flag_o[3]) && fault_irq_enable_i[3] |-> fault_irq_o[3])
      else $error("irq not latched");
   force_a: assert property ($rose(fault_pin_state_o[0]) && disable_map_o == 8'hFF |-> pwm_o == 6'h00)
      else $error("fault did not force");
   soft_a: assert property (soft_disable_bank_a_i && disable_map_o == 8'hFF |=> pwm_o == 6'h00)
      else $error("soft disable ignored");
   enable_a: assert property ($rose(module_enable_i) && prescaler_select_i == 2'h0 |=> reload_flag_o && pwm_oe_o == 6'h3F)
      else $error("enable not prompt");
   off_a: assert property ($fell(module_enable_i) && !software_output_control_i |=> pwm_oe_o == 6'h00)
      else $error("pins not released");
   keep_flag_a: assert property ($fell(module_enable_i) && reload_flag_o && !reload_flag_ack_i |=> reload_flag_o)
      else $error("reload flag lost");
   cover property ($rose(fault_event_flag_o[0]));
   cover property (fault_irq_o != 4'h0);
   cover property ($rose(module_enable_i));
endmodule
bind pwm_fault_disable_enable pwm_fault_monitor i_mon (.clk_i, .reset_i, .fault_acknowledge_i, .fault_irq_enable_i,
   .soft_disable_bank_a_i, .module_enable_i, .prescaler_select_i, .software_output_control_i, .reload_flag_ack_i,
   .disable_map_we_i, .fault_pin_state_o, .fault_event_flag_o, .fault_irq_o, .reload_flag_o, .disable_map_o,
   .pwm_o, .pwm_oe_o);

// >>> fault_sensor_model.sv
/* Overcurrent sensor model driving the four fault pins.
   Assumes trip requests change just after a clock edge. */
`timescale 1ns/1ps
module fault_sensor_model (
   input  wire logic       clk_i,
   input  wire logic [3:0] trip_i,
   output logic      [3:0] fault_pin_o
);
   // comparator output settles one clock after the trip
   always_ff @(posedge clk_i) begin
      fault_pin_o <= trip_i;
   end
endmodule

// >>> tb_pwm_fault_disable_enable.sv
/* Testbench for the PWM fault disable block.
   Assumes the sensor model and the bound checker. */
`timescale 1ns/1ps
module tb_pwm_fault_disable_enable;
   logic clk_i = 1'b0, reset_i = 1'b1, soft_disable_bank_a_i = 1'b0, soft_disable_bank_b_i = 1'b0;
   logic disable_map_we_i = 1'b0, module_enable_i = 1'b0, load_okay_i = 1'b0, reload_irq_enable_i = 1'b0;
   logic reload_flag_ack_i = 1'b0, software_output_control_i = 1'b0, cycle_start_i = 1'b0;
   logic [3:0] trip = 4'h0, fault_pin_i, fault_reenable_auto_i = 4'hF, fault_acknowledge_i = 4'h0;
   logic [3:0] fault_irq_enable_i = 4'hF, fault_pin_state_o, fault_event_flag_o, fault_irq_o;
   logic [7:0] disable_map_wdata_i = 8'h00, disable_map_o;
   logic [5:0] software_output_bit_i = 6'h00, pwm_raw_i = 6'h3F, pwm_o, pwm_oe_o;
   logic [1:0] prescaler_select_i = 2'h0;
   logic [11:0] modulus_buf_i = 12'h000, modulus_used_o;
   logic reload_flag_o, reload_irq_o, load_values_o, generator_run_o;
   int failures = 0, total_checks = 0;
   always #10 clk_i = ~clk_i;
   fault_sensor_model i_sens (.clk_i(clk_i), .trip_i(trip), .fault_pin_o(fault_pin_i));
   pwm_fault_disable_enable i_dut (.*);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wps(input logic [3:0] exp);
      int n;
      n = 0;
      while (fault_pin_state_o !== exp && n < 12) begin
         cyc(1);
         n++;
      end
      chk("pin_state", 12'(exp), 12'(fault_pin_state_o));
      if (fault_pin_state_o !== exp) wrap_up();
   endtask
   task automatic cs();
      cycle_start_i = 1'b1;
      cyc(1);
      cycle_start_i = 1'b0;
      cyc(1);
   endtask
   task automatic ack(input int i);
      fault_acknowledge_i = 4'h1 << i;
      cyc(1);
      fault_acknowledge_i = 4'h0;
      cyc(1);
   endtask
   task automatic wmap(input logic [7:0] v);
      disable_map_wdata_i = v;
      disable_map_we_i = 1'b1;
      cyc(1);
      disable_map_we_i = 1'b0;
      cyc(1);
   endtask
   task automatic pw(input logic [5:0] v);
      chk("pwm", 12'(v), 12'(pwm_o));
   endtask
   initial begin
      cyc(8);
      reset_i = 1'b0;
      chk("map_rst", 12'h0FF, 12'(disable_map_o));
      module_enable_i = 1'b1;
      cyc(1);
      chk("reload", 12'h001, 12'(reload_flag_o));
      chk("oe", 12'h03F, 12'(pwm_oe_o));
      chk("load", 12'h001, 12'(load_values_o));
      chk("run", 12'h001, 12'(generator_run_o));
      chk("mod", 12'(fault_ctl_pkg::MOD_RESET), 12'(modulus_used_o));
      chk("rl_irq", 12'h000, 12'(reload_irq_o));
      cyc(1);
      pw(6'h3F);
      trip = 4'h1;
      cyc(1);
      trip = 4'h0;
      cyc(6);
      chk("glitch", 12'h000, 12'(fault_event_flag_o));
      for (int i = 0; i < 4; i++) begin
         trip = 4'h1 << i;
         wps(4'h1 << i);
         chk("flag", 12'(4'h1 << i), 12'(fault_event_flag_o));
         chk("irq", 12'(4'h1 << i), 12'(fault_irq_o));
         pw(6'h00);
         trip = 4'h0;
         wps(4'h0);
         pw(6'h00);
         ack(i);
         chk("flag_clr", 12'h000, 12'(fault_event_flag_o | fault_irq_o));
         pw(6'h00);
         cs();
         pw(6'h3F);
      end
      fault_reenable_auto_i = 4'h0;
      for (int i = 0; i < 2; i++) begin
         trip = 4'h1 << i;
         wps(4'h1 << i);
         cs();
         pw(6'h00);
         ack(i);
         cs();
         pw(i == 0 ? 6'h3F : 6'h00);
         trip = 4'h0;
         wps(4'h0);
         cs();
         pw(6'h3F);
      end
      trip = 4'h4;
      wps(4'h4);
      fault_irq_enable_i = 4'h0;
      cyc(1);
      chk("irq_off", 12'h004, 12'({fault_irq_o, fault_event_flag_o}));
      fault_irq_enable_i = 4'hF;
      trip = 4'h0;
      wps(4'h0);
      ack(2);
      cs();
      soft_disable_bank_b_i = 1'b1;
      cyc(1);
      pw(6'h00);
      chk("soft_flag", 12'h000, 12'({fault_irq_o, fault_event_flag_o}));
      soft_disable_bank_b_i = 1'b0;
      cyc(1);
      pw(6'h00);
      cs();
      wmap(8'h01);
      wmap(8'hFF);
      chk("map", 12'h001, 12'(disable_map_o));
      soft_disable_bank_a_i = 1'b1;
      pwm_raw_i = 6'h2A;
      cyc(2);
      pw(6'h28);
      soft_disable_bank_a_i = 1'b0;
      cs();
      soft_disable_bank_b_i = 1'b1;
      cyc(2);
      pw(6'h2A);
      soft_disable_bank_b_i = 1'b0;
      module_enable_i = 1'b0;
      cyc(1);
      chk("oe_off", 12'h000, 12'(pwm_oe_o));
      chk("reload_kept", 12'h001, 12'(reload_flag_o));
      software_output_control_i = 1'b1;
      software_output_bit_i = 6'h15;
      cyc(2);
      chk("oe_sw", 12'h03F, 12'(pwm_oe_o));
      trip = 4'h1;
      wps(4'h1);
      pw(6'h14);
      ack(0);
      cyc(1);
      pw(6'h15);
      wrap_up();
   end
endmodule
